// *** pkg/sbac_consts.svh ***
// Offsets, field positions and reset values of the bus access block
`ifndef SBAC_CONSTS_SVH
`define SBAC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (word addresses)
// ----------------------------------------------------------------
`define SBAC_IDX_CTRL      8'h38
`define SBAC_IDX_ADDR_LO   8'h39
`define SBAC_IDX_DATA_LO   8'h3C
`define SBAC_IDX_IRQ_STAT  8'h50
`define SBAC_IDX_IRQ_MASK  8'h51

// ----------------------------------------------------------------
// Field positions of the control register
// ----------------------------------------------------------------
`define SBAC_VER_HI        31
`define SBAC_VER_LO        29
`define SBAC_BUSYERR_BIT   22
`define SBAC_BUSY_BIT      21
`define SBAC_RDADDR_BIT    20
`define SBAC_SIZE_HI       19
`define SBAC_SIZE_LO       17
`define SBAC_AUTOINC_BIT   16
`define SBAC_RDDATA_BIT    15
`define SBAC_ERR_HI        14
`define SBAC_ERR_LO        12
`define SBAC_ASIZE_HI      11
`define SBAC_ASIZE_LO      5
`define SBAC_CAPS_HI       4
`define SBAC_CAPS_LO       0

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SBAC_VERSION       3'h1
`define SBAC_SIZE_RESET    3'h2
`define SBAC_SIZE_MAX      3'h4
`define SBAC_ERR_NONE      3'h0
`define SBAC_ERR_SIZE      3'h4
`define SBAC_ERR_OTHER     3'h7
`define SBAC_IRQ_DONE      0
`define SBAC_IRQ_BUSYERR   1
`define SBAC_IRQ_BUSERR    2
`define SBAC_IRQ_W         3

`endif

// *** pkg/sbac_pkg.sv ***
// Types of the bus access block
package sbac_pkg;

  typedef enum logic [1:0] {
    SBAC_IDLE = 2'b00,
    SBAC_REQ  = 2'b01,
    SBAC_WAIT = 2'b10
  } sbac_state_t;

  typedef struct packed {
    logic        busy_err;
    logic        rd_on_addr;
    logic [2:0]  size;
    logic        auto_inc;
    logic        rd_on_data;
    logic [2:0]  err;
  } sbac_ctrl_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sbac_bus_req_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } sbac_bus_rsp_t;

endpackage : sbac_pkg

// *** rtl/sbac_ctrl.sv ***
// System bus access control and status with its bus manager
// Operation
// [R1] Version field bits 31:29 reads one
// [R2] Busy error on access while busy
// [R3] Busy error sticky, W1C, blocks accesses
// [R4] Busy high from request until completion
// [R5] Debugger writes control only when idle
// [R6] Address-low write starts read if enabled
// [R7] Size field selects width, resets to 2
// [R8] Unsupported size skips access, error 4
// [R9] Auto-increment adds size bytes after access
// [R10] Data-low read starts read if enabled
// [R11] Bus error sticky W1C, blocks accesses
// [R12] Error codes: timeout, address, alignment, size, other; only size (4) and other (7) are reported
// [R13] Address width field bits 11:5 read-only
// [R14] Capability bits 4:0 read-only fixed
// [R15] Address write while busy: busy error only
// [R16] Data-low write performs bus write
// [R17] Bits 28:23 read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "sbac_consts.svh"

module sbac_ctrl
  import sbac_pkg::*;
#(
  parameter logic [6:0] ADDR_WIDTH = 7'h20,
  parameter logic [4:0] SIZE_CAPS  = 5'h07
)(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  output sbac_bus_req_t      bus_req,
  input  wire sbac_bus_rsp_t bus_rsp,
  output logic               irq
);

  // Only the low address and data words exist, so the bus is 32 bits
  // wide and wider sizes fall to the capability check. A failed bus
  // answer reports code 7; finer codes are left to the target.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // [R7] Size resets to the 32-bit code, all switches off
  localparam sbac_ctrl_t CTRL_RESET = '{
    busy_err: 1'b0, rd_on_addr: 1'b0, size: `SBAC_SIZE_RESET,
    auto_inc: 1'b0, rd_on_data: 1'b0, err: `SBAC_ERR_NONE};
  // Reserved gap between the version and the busy error
  localparam int RSVD_W = `SBAC_VER_LO - `SBAC_BUSYERR_BIT - 1;
  sbac_state_t state_r;
  sbac_state_t state_nxt;
  sbac_ctrl_t  ctrl_r;
  sbac_ctrl_t  ctrl_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic [31:0] data_r;
  logic [31:0] data_nxt;
  logic        write_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [`SBAC_IRQ_W-1:0] istat_r;
  logic [`SBAC_IRQ_W-1:0] istat_nxt;
  logic [`SBAC_IRQ_W-1:0] imask_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // [R4] Busy covers the width check and the bus cycle
  wire logic busy      = (state_r != SBAC_IDLE);
  // Register selects
  wire logic hit_ctrl  = (reg_addr == `SBAC_IDX_CTRL);
  wire logic hit_alo   = (reg_addr == `SBAC_IDX_ADDR_LO);
  wire logic hit_dlo   = (reg_addr == `SBAC_IDX_DATA_LO);
  wire logic hit_istat = (reg_addr == `SBAC_IDX_IRQ_STAT);
  wire logic hit_imask = (reg_addr == `SBAC_IDX_IRQ_MASK);
  wire logic wr_ctrl   = reg_wr && hit_ctrl;
  wire logic wr_alo    = reg_wr && hit_alo;
  wire logic wr_dlo    = reg_wr && hit_dlo;
  wire logic rd_dlo    = reg_rd && hit_dlo;
  // Either error field blocks every new access
  wire logic blocked   = ctrl_r.busy_err || (ctrl_r.err != `SBAC_ERR_NONE);

  // [R2] Busy-error sources
  wire logic busy_hit  = busy && (wr_alo || wr_dlo || rd_dlo);

  // [R6] Read on address write
  wire logic go_ra     = wr_alo && !busy && !blocked && ctrl_r.rd_on_addr;
  // [R10] Read on data read
  wire logic go_rd     = rd_dlo && !busy && !blocked && ctrl_r.rd_on_data;
  // [R16] Write on data write
  wire logic go_wr     = wr_dlo && !busy && !blocked;
  wire logic go        = go_ra || go_rd || go_wr;
  // Direction latched at the trigger, held through the access
  wire logic write_nxt = go ? go_wr : write_r;

  // [R7] Supported width check
  wire logic size_ok   = (ctrl_r.size <= `SBAC_SIZE_MAX) &&
                         SIZE_CAPS[ctrl_r.size];
  // Byte count of one access, for auto-increment
  wire logic [31:0] inc_bytes = 32'h1 << ctrl_r.size;

  // An address write lands at the trigger edge, so the read that it
  // starts sees the new address without a bypass

  // ----------------------------------------------------------------
  // Bus manager
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SBAC_IDLE:
      begin
        // [R4] Busy rises with the request
        if (go)
          state_nxt = SBAC_REQ;
      end
      SBAC_REQ:
      begin
        // One cycle to vet the width before the bus sees anything
        // [R8] Bad width ends access without a bus cycle
        state_nxt = size_ok ? SBAC_WAIT : SBAC_IDLE;
      end
      SBAC_WAIT:
      begin
        // [R4] Busy holds until the response
        if (bus_rsp.done)
          state_nxt = SBAC_IDLE;
      end
      default:
        state_nxt = SBAC_IDLE;
    endcase
  end

  wire logic rsp_ok  = (state_r == SBAC_WAIT) && bus_rsp.done && !bus_rsp.err;
  wire logic rsp_bad = (state_r == SBAC_WAIT) && bus_rsp.done && bus_rsp.err;
  wire logic size_bad = (state_r == SBAC_REQ) && !size_ok;

  // ----------------------------------------------------------------
  // Bus request
  // ----------------------------------------------------------------
  assign bus_req.req   = (state_r == SBAC_WAIT);
  assign bus_req.write = write_r;
  assign bus_req.size  = ctrl_r.size;
  assign bus_req.addr  = addr_r;
  assign bus_req.wdata = data_r;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Write-data fields of the control word
  wire logic       wd_busy_err   = reg_wdata[`SBAC_BUSYERR_BIT];
  wire logic       wd_rd_on_addr = reg_wdata[`SBAC_RDADDR_BIT];
  wire logic [2:0] wd_size       = reg_wdata[`SBAC_SIZE_HI:`SBAC_SIZE_LO];
  wire logic       wd_auto_inc   = reg_wdata[`SBAC_AUTOINC_BIT];
  wire logic       wd_rd_on_data = reg_wdata[`SBAC_RDDATA_BIT];
  wire logic [2:0] wd_err        = reg_wdata[`SBAC_ERR_HI:`SBAC_ERR_LO];
  // Settings move only while idle; mid-access they would tear the request
  wire logic       ctrl_take     = wr_ctrl && !busy;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    // [R5] Settings written only when idle; ignored while busy
    if (ctrl_take)
    begin
      ctrl_nxt.rd_on_addr = wd_rd_on_addr;
      ctrl_nxt.size       = wd_size;
      ctrl_nxt.auto_inc   = wd_auto_inc;
      ctrl_nxt.rd_on_data = wd_rd_on_data;
    end
    // [R3] Write one clears the busy error
    if (wr_ctrl && wd_busy_err)
      ctrl_nxt.busy_err = 1'b0;
    // [R11] Write one clears error bits
    if (wr_ctrl)
      ctrl_nxt.err = ctrl_r.err & ~wd_err;
    // Set beats clear in the same cycle
    if (busy_hit)
      ctrl_nxt.busy_err = 1'b1;
    // [R8] Unsupported size reports code 4
    if (size_bad)
      ctrl_nxt.err = `SBAC_ERR_SIZE;
    // [R12] Bus fault reported as other
    if (rsp_bad)
      ctrl_nxt.err = `SBAC_ERR_OTHER;
  end

  // ----------------------------------------------------------------
  // Address and data
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    // [R15] Address write while busy leaves the address unchanged
    if (wr_alo && !busy)
      addr_nxt = reg_wdata;
    // [R16] Data captured for the bus write
    if (wr_dlo && !busy && !blocked)
      data_nxt = reg_wdata;
    // [R9] Auto-increment after a good access
    if (rsp_ok && ctrl_r.auto_inc)
      addr_nxt = addr_r + inc_bytes;
    // A good read lands in the data word
    if (rsp_ok && !write_r)
      data_nxt = bus_rsp.rdata;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire logic                   err_evt   = size_bad || rsp_bad;
  wire logic [`SBAC_IRQ_W-1:0] ievt      = {err_evt, busy_hit, rsp_ok};
  wire logic                   wr_istat  = reg_wr && hit_istat;
  wire logic                   wr_imask  = reg_wr && hit_imask;
  wire logic [`SBAC_IRQ_W-1:0] wd_irq    = reg_wdata[`SBAC_IRQ_W-1:0];
  // Clear only by writing one; a zero leaves the bit alone
  wire logic [`SBAC_IRQ_W-1:0] iclr      = wr_istat ? wd_irq : '0;
  wire logic [`SBAC_IRQ_W-1:0] imask_nxt = wr_imask ? wd_irq : imask_r;

  // Set wins over clear, so an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < `SBAC_IRQ_W; gi = gi + 1)
    begin : g_istat
      assign istat_nxt[gi] = ievt[gi] || (istat_r[gi] && !iclr[gi]);
    end
  endgenerate

  // Level output; software clears the cause, not the pin
  assign irq = |(istat_r & imask_r);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [31:0] ctrl_view;
  // [R1] [R13] [R14] [R17] Fixed and reserved fields
  assign ctrl_view = {`SBAC_VERSION, {RSVD_W{1'b0}}, ctrl_r.busy_err, busy,
                      ctrl_r.rd_on_addr, ctrl_r.size, ctrl_r.auto_inc,
                      ctrl_r.rd_on_data, ctrl_r.err, ADDR_WIDTH, SIZE_CAPS};

  // Idle cycles and unmapped indices read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd)
    begin
      if (hit_ctrl)
        rdata_nxt = ctrl_view;
      else if (hit_alo)
        rdata_nxt = addr_r;
      else if (hit_dlo)
        rdata_nxt = data_r;
      else if (hit_istat)
        rdata_nxt = {29'h0, istat_r};
      else if (hit_imask)
        rdata_nxt = {29'h0, imask_r};
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Bus manager state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_r <= SBAC_IDLE;
    else
      state_r <= state_nxt;
  end

  // Control fields
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctrl_r <= CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  // Bus address
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      addr_r <= 32'h0000_0000;
    else
      addr_r <= addr_nxt;
  end

  // Bus data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      data_r <= 32'h0000_0000;
    else
      data_r <= data_nxt;
  end

  // Access direction
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      write_r <= 1'b0;
    else
      write_r <= write_nxt;
  end

  // Read data, standing for one cycle only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  // Interrupt status
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      istat_r <= '0;
    else
      istat_r <= istat_nxt;
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      imask_r <= '0;
    else
      imask_r <= imask_nxt;
  end

endmodule : sbac_ctrl
`default_nettype wire

// *** test/sbac_checker.sv ***
// Assertion checker of the bus access block
`timescale 1ns/1ps
`default_nettype none
module sbac_checker
  import sbac_pkg::*;
#(
  parameter logic [6:0] ADDR_WIDTH = 7'h20,
  parameter logic [4:0] SIZE_CAPS  = 5'h07
)(
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire sbac_bus_req_t bus_req,
  input wire sbac_bus_rsp_t bus_rsp
);
  logic blk_r;
  wire  ctl_rd = reg_rd && reg_addr == 8'h38;
  // Bus error pending until all error bits written
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      blk_r <= 1'b0;
    else if (bus_req.req && bus_rsp.done && bus_rsp.err)
      blk_r <= 1'b1;
    else if (reg_wr && reg_addr == 8'h38 && reg_wdata[14:12] == 3'h7)
      blk_r <= 1'b0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_version_field: assert property (
    ctl_rd |=> reg_rdata[31:29] == 3'h1) else $error("version bad");
  chk_unused_zero: assert property (
    ctl_rd |=> reg_rdata[28:23] == 6'h0) else $error("unused bits set");
  chk_caps_fixed: assert property (
    ctl_rd |=> reg_rdata[11:0] == {ADDR_WIDTH, SIZE_CAPS})
    else $error("caps bad");
  chk_req_holds: assert property (
    bus_req.req && !bus_rsp.done |=> bus_req.req) else $error("req drop");
  chk_req_ends: assert property (
    bus_req.req && bus_rsp.done |=> !bus_req.req) else $error("req stuck");
  chk_size_legal: assert property (
    bus_req.req |-> bus_req.size <= 3'h4 && SIZE_CAPS[bus_req.size])
    else $error("bad size sent");
  chk_req_cause: assert property (
    $rose(bus_req.req) |-> $past(reg_wr, 2) || $past(reg_rd, 2))
    else $error("req without cause");
  chk_write_kind: assert property (
    $rose(bus_req.req) |-> bus_req.write ==
    ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h3C))
    else $error("req kind");
  chk_err_blocks: assert property (
    blk_r |-> !$rose(bus_req.req)) else $error("req after error");
endmodule : sbac_checker
bind sbac_ctrl sbac_checker #(.ADDR_WIDTH(ADDR_WIDTH), .SIZE_CAPS(SIZE_CAPS))
  i_sbac_checker (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .bus_req, .bus_rsp);
`default_nettype wire

// *** test/sbac_bus_model.sv ***
// System bus target answering after a set latency
`timescale 1ns/1ps
`default_nettype none
module sbac_bus_model
  import sbac_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire sbac_bus_req_t bus_req,
  input  wire logic [3:0]    lat,
  input  wire logic          fail,
  output sbac_bus_rsp_t      bus_rsp
);
  logic [3:0] cnt_r;
  wire        hit = bus_req.req && !bus_rsp.done && cnt_r == lat;
  // Data inverted outside answers, never a stale copy
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      cnt_r   <= 4'h0;
      bus_rsp <= '0;
    end
    else
    begin
      cnt_r         <= bus_req.req && !hit ? cnt_r + 4'h1 : 4'h0;
      bus_rsp.done  <= hit;
      bus_rsp.err   <= hit && fail;
      bus_rsp.rdata <= hit ? ~bus_req.addr : ~bus_rsp.rdata;
    end
endmodule : sbac_bus_model
`default_nettype wire

// *** test/sbac_ctrl_test.sv ***
// Testbench of the bus access block
`timescale 1ns/1ps
`default_nettype none
`include "sbac_consts.svh"
module sbac_ctrl_test
  import sbac_pkg::*;
;
  logic          sys_clk, rst, reg_wr, reg_rd, fail, irq;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, v;
  logic [3:0]    lat;
  sbac_bus_req_t bus_req;
  sbac_bus_rsp_t bus_rsp;
  int            mismatches, checked;
  localparam logic [31:0] DEF = 32'h2004_0407;
  sbac_ctrl i_sbac_ctrl (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bus_req, .bus_rsp, .irq);
  sbac_bus_model i_sbac_bus_model (.sys_clk, .rst, .bus_req, .lat, .fail,
    .bus_rsp);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  task idle;
    for (int i = 0; i < 40; i++)
    begin
      rd(`SBAC_IDX_CTRL);
      if (v[21] === 1'b0)
        return;
    end
    chk("busy", 32'h0, v);
    summarize();
  endtask : idle
  task t_write;
    for (int s = 0; s < 3; s++)
    begin
      wr(`SBAC_IDX_CTRL, 32'h0001_0000 | (s << 17));
      wr(`SBAC_IDX_ADDR_LO, 32'h100);
      wr(`SBAC_IDX_DATA_LO, 32'hCAFE_0001);
      #1;
      for (int i = 0; i < 20 && bus_req.req !== 1'b1; i++)
        #100;
      if (bus_req.req !== 1'b1)
      begin
        chk("req seen", 32'h1, {31'h0, bus_req.req});
        summarize();
      end
      chk("req addr", 32'h100, bus_req.addr);
      chk("req data", 32'hCAFE_0001, bus_req.wdata);
      chk("req kind", 32'h8 | s, {28'h0, bus_req.write, bus_req.size});
      @(posedge sys_clk);
      idle();
      rd(`SBAC_IDX_ADDR_LO);
      chk("inc addr", 32'h100 + (1 << s), v);
    end
  endtask : t_write
  task t_reads;
    wr(`SBAC_IDX_CTRL, 32'h0015_8000);
    wr(`SBAC_IDX_ADDR_LO, 32'h200);
    idle();
    rd(`SBAC_IDX_DATA_LO);
    chk("addr read", ~32'h200, v);
    idle();
    rd(`SBAC_IDX_DATA_LO);
    chk("data read", ~32'h204, v);
    idle();
    rd(`SBAC_IDX_ADDR_LO);
    // The second data read started one more read, hence three steps
    chk("read inc", 32'h20C, v);
  endtask : t_reads
  task t_busy;
    lat <= 4'h8;
    wr(`SBAC_IDX_CTRL, 32'h0004_0000);
    wr(`SBAC_IDX_ADDR_LO, 32'h300);
    wr(`SBAC_IDX_DATA_LO, 32'h1);
    wr(`SBAC_IDX_ADDR_LO, 32'h400);
    rd(`SBAC_IDX_CTRL);
    chk("busy set", DEF | 32'h60_0000, v);
    idle();
    chk("busy err", DEF | 32'h40_0000, v);
    rd(`SBAC_IDX_ADDR_LO);
    chk("addr kept", 32'h300, v);
    wr(`SBAC_IDX_DATA_LO, 32'h2);
    rd(`SBAC_IDX_CTRL);
    chk("blocked", DEF | 32'h40_0000, v);
    wr(`SBAC_IDX_CTRL, 32'h0044_0000);
    rd(`SBAC_IDX_CTRL);
    chk("busy err clr", DEF, v);
    lat <= 4'h0;
  endtask : t_busy
  task t_err;
    logic [31:0] c [3] = '{32'h6_0000, 32'h8_0000, 32'h4_0000};
    logic [2:0]  e [3] = '{3'h4, 3'h4, 3'h7};
    wr(`SBAC_IDX_IRQ_MASK, 32'h4);
    chk("irq masked", 32'h0, irq);
    for (int i = 0; i < 3; i++)
    begin
      fail <= i == 2;
      wr(`SBAC_IDX_CTRL, c[i]);
      wr(`SBAC_IDX_DATA_LO, 32'h5);
      idle();
      chk("err code", e[i], v[14:12]);
      chk("irq", 32'h1, irq);
      wr(`SBAC_IDX_DATA_LO, 32'h6);
      idle();
      chk("err kept", e[i], v[14:12]);
      wr(`SBAC_IDX_CTRL, 32'h0004_7000);
      wr(`SBAC_IDX_IRQ_STAT, 32'h7);
      rd(`SBAC_IDX_CTRL);
      chk("err clr", DEF, v);
      chk("irq clr", 32'h0, irq);
    end
    fail <= 1'b0;
  endtask : t_err
  initial
  begin
    {rst, reg_wr, reg_rd, fail} = 4'h8;
    reg_addr   = 8'h0;
    reg_wdata  = 32'h0;
    lat        = 4'h1;
    mismatches = 0;
    checked    = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`SBAC_IDX_CTRL);
    chk("ctrl reset", DEF, v);
    wr(`SBAC_IDX_CTRL, 32'hDF84_0FFF);
    rd(`SBAC_IDX_CTRL);
    chk("ctrl fixed", DEF, v);
    rd(8'h70);
    chk("unmapped", 32'h0, v);
    t_write();
    t_reads();
    t_busy();
    t_err();
    summarize();
  end
endmodule : sbac_ctrl_test
`default_nettype wire
